// ==== core/wdt_defs.svh ====
`ifndef WDT_DEFS_SVH
`define WDT_DEFS_SVH

// Register byte offsets
`define WD_CSR1_OFS 4'h0
`define WD_CSR2_OFS 4'h4
`define WD_CNT_OFS 4'h8

// First control/status register fields
`define WD1_CNT_WE 7
`define WD1_CNT_WE_GUARD 6
`define WD1_GWE_GUARD 5
`define WD1_GWE 4
`define WD1_RUN_GUARD 3
`define WD1_RUN 2
`define WD1_RF_GUARD 1
`define WD1_WATCHDOG_RESET_FLAG 0

// Second control/status register fields
`define WD2_OVF 7
`define WD2_MODE_GUARD 6
`define WD2_MODE 5
`define WD2_IE_GUARD 4
`define WD2_IE 3
`define WD2_RSVD 3'h7

// Reset values and counts
`define WD_RUN_RESET 1'h1
`define WD_CNT_RESET 8'h00
`define WD_CNT_MAX 8'hff
`define WD_CNT_ONE 8'h01
`define WD_RST_OSC_LAST 10'h1ff
`define WD_RST_OSC_ONE 10'h001
`define WD_RST_OSC_ZERO 10'h000
`define WD_BUS_PAD 24'h000000

`endif

// ==== core/wdt_pkg.sv ====
package wdt_pkg;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_s;

  typedef enum logic {ST_RUN, ST_HOLD} wd_state_e;

endpackage

// ==== core/watchdog_interval_timer_ctrl.sv ====
// Function
// - Run bit resets to 1; counter counts while 1, holds while 0.
// - Run bit written only with its guard bit written 0 and write enable set.
// - Reset-flag guard bit reads 1; flag write needs guard written 0.
// - Watchdog reset flag clears on pin reset, set by overflow reset only.
// - Writing 0 with guard 0 and write enable set clears the reset flag.
// - Overflow flag resets to 0, set when counter wraps from ff to 00.
// - Watchdog-mode internal reset clears the overflow flag after it is set.
// - Besides resets, overflow flag clears only by writing 0 after reading it as 1.
// - Mode guard bit reads 1; mode write needs guard written 0.
// - Mode bit resets to 0; 0 is watchdog, 1 is interval timer.
// - Enable guard bit reads 1; enable write needs guard written 0.
// - Interrupt enable resets to 0 and gates interval-mode interrupt requests.
// - Reserved bits 2 to 0 of second register always read 1.
// - Readable, writable 8-bit up-counter initialised to 00.
// - Watchdog-mode wrap asserts internal reset and sets the reset flag.
// - Run bit and reset flag writable only while write enable is 1.
// - Internal reset lasts 512 watchdog oscillator cycles.
// - Written counter value is the start point for further counting.
// - Interval-mode overflow requests an interrupt instead of a reset.
//
// The implementer's own choices: the Wishbone register port and the register addresses.
`include "wdt_defs.svh"

module watchdog_interval_timer_ctrl (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire wdt_pkg::wb_req_s wb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic count_tick_i,
  input wire logic osc_tick_i,
  output logic wd_reset_o,
  output logic irq_o
);
  import wdt_pkg::*;

  logic run, watchdog_reset_flag, gwe, cwe, mode, ie, ovf, ovf_armed, ack;
  logic next_run, next_watchdog_reset_flag, next_gwe, next_cwe, next_mode, next_ie;
  logic next_ovf, next_ovf_armed, next_ack;
  logic [7:0] count, next_count, rdat, next_rdat;
  logic [9:0] osc_cnt, next_osc_cnt;
  wd_state_e state, next_state;
  logic req, wr, rd, hit1, hit2, hitc, tick, ovf_evt, wd_evt;
  logic [7:0] wdat, csr1_val, csr2_val;

  always_comb begin
    req = wb_i.cyc & wb_i.stb;
    wr = req & wb_i.we & ack & wb_i.sel[0];
    rd = req & ~wb_i.we & ack;
    hit1 = wb_i.adr == `WD_CSR1_OFS;
    hit2 = wb_i.adr == `WD_CSR2_OFS;
    hitc = wb_i.adr == `WD_CNT_OFS;
    wdat = wb_i.dat[7:0];
    tick = count_tick_i & run & (state == ST_RUN);
    ovf_evt = tick & (count == `WD_CNT_MAX);
    wd_evt = ovf_evt & ~mode;
    csr1_val = {cwe, 1'b1, 1'b1, gwe, 1'b1, run, 1'b1, watchdog_reset_flag};
    csr2_val = {ovf, 1'b1, mode, 1'b1, ie, `WD2_RSVD};
  end

  // Bus answer: ack one cycle after the request, read data registered
  always_comb begin
    next_ack = req & ~ack;
    next_rdat = rdat;
    if (req & ~ack) begin
      if (hit1) begin
        next_rdat = csr1_val;
      end else if (hit2) begin
        next_rdat = csr2_val;
      end else if (hitc) begin
        next_rdat = count;
      end else begin
        next_rdat = `WD_CNT_RESET;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack <= 1'b0;
      rdat <= `WD_CNT_RESET;
    end else begin
      ack <= next_ack;
      rdat <= next_rdat;
    end
  end

  assign wb_ack_o = ack;
  assign wb_dat_o = {`WD_BUS_PAD, rdat};

  // Control, status, counter and internal reset sequencing
  always_comb begin
    next_run = run;
    next_watchdog_reset_flag = watchdog_reset_flag;
    next_gwe = gwe;
    next_cwe = cwe;
    next_mode = mode;
    next_ie = ie;
    next_ovf = ovf;
    next_ovf_armed = ovf_armed;
    next_count = count;
    next_osc_cnt = osc_cnt;
    next_state = state;
    if (tick) begin
      next_count = count + `WD_CNT_ONE;
    end
    if (wr & hitc & cwe) begin
      next_count = wdat;
    end
    if (wr & hit1) begin
      if (!wdat[`WD1_CNT_WE_GUARD]) begin
        next_cwe = wdat[`WD1_CNT_WE];
      end
      if (!wdat[`WD1_GWE_GUARD]) begin
        next_gwe = wdat[`WD1_GWE];
      end
      if (gwe & !wdat[`WD1_RUN_GUARD]) begin
        next_run = wdat[`WD1_RUN];
      end
      if (gwe & !wdat[`WD1_RF_GUARD] & !wdat[`WD1_WATCHDOG_RESET_FLAG]) begin
        next_watchdog_reset_flag = 1'b0;
      end
    end
    if (rd & hit2 & ovf) begin
      next_ovf_armed = 1'b1;
    end
    if (wr & hit2) begin
      if (!wdat[`WD2_MODE_GUARD]) begin
        next_mode = wdat[`WD2_MODE];
      end
      if (!wdat[`WD2_IE_GUARD]) begin
        next_ie = wdat[`WD2_IE];
      end
      if (ovf_armed & !wdat[`WD2_OVF]) begin
        next_ovf = 1'b0;
        next_ovf_armed = 1'b0;
      end
    end
    case (state)
      ST_RUN: begin
        if (wd_evt) begin
          next_state = ST_HOLD;
          next_osc_cnt = `WD_RST_OSC_ZERO;
        end
      end
      ST_HOLD: begin
        // Internal reset reinitialises all but the reset flag
        next_run = `WD_RUN_RESET;
        next_gwe = 1'b0;
        next_cwe = 1'b0;
        next_mode = 1'b0;
        next_ie = 1'b0;
        next_ovf = 1'b0;
        next_ovf_armed = 1'b0;
        next_count = `WD_CNT_RESET;
        if (osc_tick_i) begin
          if (osc_cnt == `WD_RST_OSC_LAST) begin
            next_state = ST_RUN;
          end else begin
            next_osc_cnt = osc_cnt + `WD_RST_OSC_ONE;
          end
        end
      end
      default: begin
        next_state = ST_RUN;
      end
    endcase
    if (ovf_evt) begin
      next_ovf = 1'b1;
    end
    if (wd_evt) begin
      next_watchdog_reset_flag = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run <= `WD_RUN_RESET;
      watchdog_reset_flag <= 1'b0;
      gwe <= 1'b0;
      cwe <= 1'b0;
      mode <= 1'b0;
      ie <= 1'b0;
      ovf <= 1'b0;
      ovf_armed <= 1'b0;
      count <= `WD_CNT_RESET;
      osc_cnt <= `WD_RST_OSC_ZERO;
      state <= ST_RUN;
    end else begin
      run <= next_run;
      watchdog_reset_flag <= next_watchdog_reset_flag;
      gwe <= next_gwe;
      cwe <= next_cwe;
      mode <= next_mode;
      ie <= next_ie;
      ovf <= next_ovf;
      ovf_armed <= next_ovf_armed;
      count <= next_count;
      osc_cnt <= next_osc_cnt;
      state <= next_state;
    end
  end

  assign wd_reset_o = state == ST_HOLD;
  assign irq_o = ovf & mode & ie;

  chk_run_holds: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (state == ST_RUN && !run && !(wr && hitc)) |=> count == $past(count))
    else $error("Counter moved while stopped");

  chk_run_guarded: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (state == ST_RUN && !wd_evt && wr && hit1 && !gwe)
      |=> run == $past(run))
    else $error("Run bit written without write enable");

  chk_run_written: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (state == ST_RUN && !wd_evt && wr && hit1 && gwe
      && !wdat[`WD1_RUN_GUARD]) |=> run == $past(wdat[`WD1_RUN]))
    else $error("Guarded run write not taken");

  chk_watchdog_reset_flag_set: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wd_evt |=> watchdog_reset_flag && wd_reset_o ##1 !ovf && watchdog_reset_flag)
    else $error("Watchdog overflow did not reset or flag");

  chk_reset_len: assert property (
    @(posedge clk_i) disable iff (rst_i)
    $fell(wd_reset_o) |-> $past(osc_cnt) == `WD_RST_OSC_LAST
      && $past(osc_tick_i))
    else $error("Internal reset length wrong");

  chk_ovf_set: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ovf_evt |=> ovf && (count == `WD_CNT_RESET || $past(wr && hitc && cwe)))
    else $error("Wrap did not set overflow flag");

  chk_ovf_sticky: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (ovf && !ovf_armed && state == ST_RUN && !wd_evt) |=> ovf)
    else $error("Overflow flag cleared without prior read");

  chk_mode_guard: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (state == ST_RUN && !wd_evt && wr && hit2 && wdat[`WD2_MODE_GUARD])
      |=> mode == $past(mode))
    else $error("Mode changed with guard bit set");

  chk_irq_gate: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (ovf_evt && mode && ie) |=> irq_o && !wd_reset_o)
    else $error("Interval overflow gave no interrupt");

  chk_rsvd_read: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (wb_ack_o && req && !wb_i.we && hit2)
      |-> wb_dat_o[2:0] == `WD2_RSVD && wb_dat_o[6] && wb_dat_o[4])
    else $error("Reserved or guard bits read wrong");

  chk_watchdog_reset_flag_clear: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (!wd_evt && wr && hit1 && gwe && !wdat[`WD1_RF_GUARD]
      && !wdat[`WD1_WATCHDOG_RESET_FLAG]) |=> !watchdog_reset_flag)
    else $error("Reset flag not cleared by guarded write");

  chk_watchdog_reset_flag_guard: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (!wd_evt && wr && hit1 && (!gwe || wdat[`WD1_RF_GUARD]))
      |=> watchdog_reset_flag == $past(watchdog_reset_flag))
    else $error("Reset flag written without guard");

  chk_ie_guard: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (state == ST_RUN && wr && hit2 && wdat[`WD2_IE_GUARD])
      |=> ie == $past(ie))
    else $error("Interrupt enable changed with guard bit set");

  chk_cnt_step: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (state == ST_RUN && count_tick_i && run && !(wr && hitc && cwe))
      |=> count == $past(count) + `WD_CNT_ONE)
    else $error("Counter did not step on tick");

  chk_cnt_load: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (state == ST_RUN && wr && hitc && cwe) |=> count == $past(wdat))
    else $error("Counter write not taken");

  chk_mode_write: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (state == ST_RUN && wr && hit2 && !wdat[`WD2_MODE_GUARD])
      |=> mode == $past(wdat[`WD2_MODE]))
    else $error("Guarded mode write not taken");

  chk_ovf_clear: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (ovf_armed && !ovf_evt && wr && hit2 && !wdat[`WD2_OVF]) |=> !ovf)
    else $error("Armed overflow clear not taken");

  chk_hold_clears: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wd_reset_o |=> !ovf && !ie && !mode && count == `WD_CNT_RESET)
    else $error("Internal reset left state behind");

endmodule

// ==== test/tb_top.sv ====
`include "wdt_defs.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import wdt_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  wb_req_s req = '0;
  logic [31:0] rdat;
  logic wb_ack;
  logic wd_reset;
  logic irq;
  logic tick = 1'b0;
  logic osc = 1'b1;
  int fail_count = 0;
  int tests_run = 0;
  int cycles = 0;
  int n;
  int k;

  watchdog_interval_timer_ctrl watchdog_interval_timer_ctrl_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_i(req), .wb_dat_o(rdat),
    .wb_ack_o(wb_ack), .count_tick_i(tick), .osc_tick_i(osc),
    .wd_reset_o(wd_reset), .irq_o(irq)
  );

  initial begin
    forever #50 clk_i = ~clk_i;
  end

  // Oscillator tick on every second cycle
  always @(posedge clk_i) begin
    osc <= ~osc;
  end

  task report_and_stop();
    $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      $display("[FAIL] %0t timeout", $time);
      report_and_stop();
    end
  end

  task chk_byte(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t read %h expected %h", $time, got, exp);
    end
  endtask

  task chk_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
    end
  endtask

  // One classic cycle, held until ack is sampled high
  task wb_acc(input logic w, input logic [3:0] a, input logic [7:0] d,
              output logic [7:0] q);
    @(posedge clk_i);
    req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'h1,
             dat: {24'h000000, d}};
    do begin
      @(posedge clk_i);
    end while (wb_ack !== 1'b1);
    q = rdat[7:0];
    req <= '0;
  endtask

  task wr(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] q;
    wb_acc(1'b1, a, d, q);
  endtask

  task rd(input logic [3:0] a, input logic [7:0] e);
    logic [7:0] q;
    wb_acc(1'b0, a, 8'h00, q);
    chk_byte(q, e);
  endtask

  task ticks(input int c);
    repeat (c) begin
      @(posedge clk_i);
      tick <= 1'b1;
      @(posedge clk_i);
      tick <= 1'b0;
    end
    @(posedge clk_i);
  endtask

  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`WD_CSR1_OFS, 8'h6e);
    rd(`WD_CSR2_OFS, 8'h57);
    rd(`WD_CNT_OFS, 8'h00);
    rd(4'hc, 8'h00);
    $display("Test reset values done");
    wr(`WD_CSR1_OFS, 8'h90);
    rd(`WD_CSR1_OFS, 8'hfe);
    wr(`WD_CSR1_OFS, 8'h98);
    rd(`WD_CSR1_OFS, 8'hfe);
    wr(`WD_CSR1_OFS, 8'h90);
    rd(`WD_CSR1_OFS, 8'hfa);
    wr(`WD_CNT_OFS, 8'hfd);
    ticks(2);
    rd(`WD_CNT_OFS, 8'hfd);
    wr(`WD_CSR1_OFS, 8'h94);
    ticks(2);
    rd(`WD_CNT_OFS, 8'hff);
    $display("Test run control done");
    wr(`WD_CSR2_OFS, 8'h68);
    rd(`WD_CSR2_OFS, 8'h5f);
    wr(`WD_CSR2_OFS, 8'h20);
    rd(`WD_CSR2_OFS, 8'h77);
    ticks(1);
    chk_bit(irq, 1'b0);
    rd(`WD_CSR2_OFS, 8'hf7);
    wr(`WD_CSR2_OFS, 8'hc8);
    @(posedge clk_i);
    chk_bit(irq, 1'b1);
    rd(`WD_CSR2_OFS, 8'hff);
    wr(`WD_CSR2_OFS, 8'h50);
    rd(`WD_CSR2_OFS, 8'h7f);
    chk_bit(irq, 1'b0);
    wr(`WD_CNT_OFS, 8'hff);
    ticks(1);
    chk_bit(irq, 1'b1);
    chk_bit(wd_reset, 1'b0);
    rd(`WD_CSR2_OFS, 8'hff);
    wr(`WD_CSR2_OFS, 8'h50);
    $display("Test interval mode done");
    wr(`WD_CSR2_OFS, 8'h18);
    rd(`WD_CSR2_OFS, 8'h5f);
    wr(`WD_CNT_OFS, 8'hff);
    ticks(1);
    n = 0;
    while (wd_reset !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    chk_bit(wd_reset, 1'b1);
    k = 0;
    while (wd_reset === 1'b1 && k < 1200) begin
      @(posedge clk_i);
      k++;
    end
    chk_bit(logic'(k >= 1023 && k <= 1024), 1'b1);
    rd(`WD_CSR1_OFS, 8'h6f);
    rd(`WD_CSR2_OFS, 8'h57);
    wr(`WD_CSR1_OFS, 8'h44);
    rd(`WD_CSR1_OFS, 8'h6f);
    wr(`WD_CSR1_OFS, 8'h5a);
    wr(`WD_CSR1_OFS, 8'h44);
    rd(`WD_CSR1_OFS, 8'h6e);
    $display("Test watchdog mode done");
    report_and_stop();
  end
endmodule
